/* rtl/lsm_core.sv */
`timescale 1ns/10ps
`default_nettype none

module lsm_core (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic [15:0] i_instr,
  input  wire logic        i_instr_valid,
  output logic             o_instr_ready,
  output logic             o_done,
  output logic             o_illegal,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic [1:0]       o_mem_size,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_mem_wdata,
  input  wire logic        i_mem_ack,
  input  wire logic [31:0] i_mem_rdata,
  output logic [31:0]      o_psw,
  input  wire logic [3:0]  i_dbg_sel,
  output logic [31:0]      o_dbg_gpr
);
  import lsm_pkg::*;

  logic [31:0] gpr_reg [GPR_NUM];
  logic [31:0] spr_reg [SPR_NUM];
  logic [31:0] psw_reg;
  lsm_state_t  state_reg;
  lsm_state_t  state_next;
  lsm_dst_t    pend_dst_reg;
  logic [3:0]  pend_idx_reg;
  logic        pend_pop_reg;
  logic [1:0]  pend_size_reg;
  logic [1:0]  pend_lane_reg;

  // instruction fields
  wire logic [7:0]  op;
  wire logic [3:0]  opb;
  wire logic [3:0]  fld_j;   // source_gpr, sub-code or unsigned_offset_field
  wire logic [3:0]  fld_i;   // dest_gpr or special_register_operand
  wire logic [7:0]  signed_offset_field;
  wire logic [31:0] off_sext;

  assign op                  = i_instr[15:8];
  assign opb                 = i_instr[15:12];
  assign fld_j               = i_instr[7:4];
  assign fld_i               = i_instr[3:0];
  assign signed_offset_field = i_instr[11:4];
  assign off_sext            = {{24{signed_offset_field[7]}}, signed_offset_field};

  // form decode
  wire logic grp07;
  wire logic grp17;
  wire logic ld_ind;
  wire logic ld_idx;
  wire logic ld_frm;
  wire logic ld_stk;
  wire logic st_ind;
  wire logic st_idx;
  wire logic st_frm;
  wire logic st_stk;
  wire logic pop_g;
  wire logic pop_s;
  wire logic pop_p;
  wire logic push_g;
  wire logic push_s;
  wire logic push_p;
  wire logic mov_gg;
  wire logic mov_sg;
  wire logic mov_gs;
  wire logic mov_pg;
  wire logic mov_gp;

  assign grp07  = (op == OP_POP_GRP);
  assign grp17  = (op == OP_PUSH_GRP);
  assign ld_ind = (op == OP_LDW_IND) || (op == OP_LDH_IND) || (op == OP_LDB_IND);
  assign ld_idx = (op == OP_LDW_IDX) || (op == OP_LDH_IDX) || (op == OP_LDB_IDX);
  assign ld_frm = (opb == OPB_LDW_FRM) || (opb == OPB_LDH_FRM) || (opb == OPB_LDB_FRM);
  assign ld_stk = (op == OP_LDW_STK);
  assign st_ind = (op == OP_STW_IND) || (op == OP_STH_IND) || (op == OP_STB_IND);
  assign st_idx = (op == OP_STW_IDX) || (op == OP_STH_IDX) || (op == OP_STB_IDX);
  assign st_frm = (opb == OPB_STW_FRM) || (opb == OPB_STH_FRM) || (opb == OPB_STB_FRM);
  assign st_stk = (op == OP_STW_STK);
  assign pop_g  = grp07 && (fld_j == SUB_GPR);
  assign pop_s  = grp07 && (fld_j == SUB_SPR);
  assign pop_p  = grp07 && (fld_j == SUB_PSW);
  assign mov_gp = grp07 && (fld_j == SUB_XFER);
  assign push_g = grp17 && (fld_j == SUB_GPR);
  assign push_s = grp17 && (fld_j == SUB_SPR);
  assign push_p = grp17 && (fld_j == SUB_PSW);
  assign mov_pg = grp17 && (fld_j == SUB_XFER);
  assign mov_gg = (op == OP_MOV_GG);
  assign mov_sg = (op == OP_MOV_SG);
  assign mov_gs = (op == OP_MOV_GS);

  // grouped decode
  wire logic is_pop;
  wire logic is_push;
  wire logic is_load;
  wire logic is_store;
  wire logic is_frm;
  wire logic is_ab;
  wire logic spr_i_ok;
  wire logic spr_j_ok;
  wire logic legal;
  wire logic [1:0] size_ab;
  wire logic [1:0] size_frm;
  wire logic [1:0] acc_size;

  assign is_pop   = pop_g || pop_s || pop_p;
  assign is_push  = push_g || push_s || push_p;
  assign is_load  = ld_ind || ld_idx || ld_frm || ld_stk || is_pop;
  assign is_store = st_ind || st_idx || st_frm || st_stk || is_push;
  assign is_frm   = ld_frm || st_frm;
  assign is_ab    = ld_ind || ld_idx || st_ind || st_idx;
  assign spr_i_ok = (32'(fld_i) < SPR_NUM);
  assign spr_j_ok = (32'(fld_j) < SPR_NUM);
  // special-register forms naming a missing register are refused
  assign legal    = ((is_load || is_store) && !((pop_s || push_s) && !spr_i_ok)) ||
                    mov_gg || mov_pg || mov_gp || ((mov_sg || mov_gs) && spr_j_ok);
  // low opcode bits give the size: 0 word, 1 half, 2 byte; frame forms use bits 14:13, 1 word, 2 half, 3 byte
  assign size_ab  = (op[1:0] == 2'h0) ? SZ_WORD : (op[1:0] == 2'h1) ? SZ_HALF : SZ_BYTE;
  assign size_frm = (opb[2:1] == 2'h1) ? SZ_WORD : (opb[2:1] == 2'h2) ? SZ_HALF : SZ_BYTE;
  assign acc_size = is_frm ? size_frm : is_ab ? size_ab : SZ_WORD;

  // address generation
  wire logic [31:0] sp_val;
  wire logic [31:0] sp_dec;
  wire logic [31:0] sp_inc;
  wire logic [31:0] frm_disp;
  wire logic [31:0] stk_disp;
  wire logic [31:0] acc_addr;

  assign sp_val   = gpr_reg[STACK_GPR];
  assign sp_dec   = sp_val - STACK_STEP;
  assign sp_inc   = sp_val + STACK_STEP;
  assign frm_disp = (size_frm == SZ_WORD) ? {off_sext[29:0], 2'b00} :
                    (size_frm == SZ_HALF) ? {off_sext[30:0], 1'b0} : off_sext;
  assign stk_disp = {26'h0, fld_j, 2'b00};
  assign acc_addr = (ld_ind || st_ind) ? gpr_reg[fld_j] :
                    (ld_idx || st_idx) ? gpr_reg[IDX_BASE_GPR] + gpr_reg[fld_j] :
                    is_frm             ? gpr_reg[FRAME_GPR] + frm_disp :
                    (ld_stk || st_stk) ? sp_val + stk_disp :
                    is_push            ? sp_dec : sp_val;                        // pop reads at sp

  // store data source
  wire logic [31:0] st_src;
  assign st_src = push_s ? spr_reg[fld_i[2:0]] : push_p ? psw_reg : gpr_reg[fld_i];

  // lane steering for reads and writes
  wire logic [31:0] rd_ext;
  wire logic [31:0] wd_lanes;

  lsm_lane_ext u_lane (
    .i_size        (o_mem_req ? pend_size_reg : acc_size),
    .i_lane        (o_mem_req ? pend_lane_reg : acc_addr[1:0]),
    .i_rdata       (i_mem_rdata),
    .i_wdata       (st_src),
    .o_rdata_ext   (rd_ext),
    .o_wdata_lanes (wd_lanes)
  );

  // handshake terms
  wire logic take;
  wire logic take_ok;
  wire logic mem_end;

  // ready stays low while a form is in flight: the register interlock
  assign take    = i_instr_valid && o_instr_ready;
  assign take_ok = take && legal;
  assign mem_end = (state_reg == ST_MEM) && i_mem_ack;

  // register write ports
  wire logic        gw_en;
  wire logic [3:0]  gw_idx;
  wire logic [31:0] gw_data;
  wire logic        sp_we;
  wire logic [31:0] sp_data;
  wire logic        sw_en;
  wire logic [2:0]  sw_idx;
  wire logic [31:0] sw_data;
  wire logic        pw_en;
  wire logic [31:0] pw_data;

  assign gw_en   = (take_ok && (mov_gg || mov_sg || mov_pg)) ||
                   (mem_end && (pend_dst_reg == DST_GPR));
  assign gw_idx  = (state_reg == ST_MEM) ? pend_idx_reg : fld_i;
  assign gw_data = (state_reg == ST_MEM) ? rd_ext :
                   mov_sg ? spr_reg[fld_j[2:0]] : mov_pg ? psw_reg : gpr_reg[fld_j];
  // push moves sp at issue, pop after the data is back
  assign sp_we   = (take_ok && is_push) || (mem_end && pend_pop_reg);
  assign sp_data = (state_reg == ST_MEM) ? sp_inc : sp_dec;
  assign sw_en   = (take_ok && mov_gs) || (mem_end && (pend_dst_reg == DST_SPR));
  assign sw_idx  = (state_reg == ST_MEM) ? pend_idx_reg[2:0] : fld_j[2:0];
  assign sw_data = (state_reg == ST_MEM) ? rd_ext : gpr_reg[fld_i];
  assign pw_en   = (take_ok && mov_gp) || (mem_end && (pend_dst_reg == DST_PSW));
  assign pw_data = (state_reg == ST_MEM) ? rd_ext : gpr_reg[fld_i];

  // sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (take_ok && (is_load || is_store)) begin
          state_next = ST_MEM;
        end else if (take_ok && mov_gp) begin
          state_next = ST_PSFIX;
        end
      end
      ST_MEM: begin
        if (i_mem_ack) begin
          state_next = (pend_dst_reg == DST_PSW) ? ST_PSFIX : ST_IDLE;
        end
      end
      ST_PSFIX: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // general registers; a load landing in the stack register beats the pop step
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < GPR_NUM; k++) begin
        gpr_reg[k] <= GPR_RST;
      end
    end else begin
      if (sp_we) begin
        gpr_reg[STACK_GPR] <= sp_data;
      end
      if (gw_en) begin
        gpr_reg[gw_idx] <= gw_data;
      end
    end
  end

  // special registers and status word; copies other than the one into the status word leave the flags alone
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < SPR_NUM; k++) begin
        spr_reg[k] <= SPR_RST;
      end
      psw_reg <= PSW_RST;
    end else begin
      if (sw_en) begin
        spr_reg[sw_idx] <= sw_data;
      end
      if (pw_en) begin
        psw_reg <= pw_data;
      end
    end
  end

  // pending access bookkeeping, captured when the access issues
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_dst_reg  <= DST_NONE;
      pend_idx_reg  <= 4'h0;
      pend_pop_reg  <= 1'b0;
      pend_size_reg <= SZ_WORD;
      pend_lane_reg <= 2'h0;
    end else if (take_ok && (is_load || is_store)) begin
      pend_dst_reg  <= !is_load ? DST_NONE : pop_s ? DST_SPR : pop_p ? DST_PSW : DST_GPR;
      pend_idx_reg  <= fld_i;
      pend_pop_reg  <= is_pop;
      pend_size_reg <= acc_size;
      pend_lane_reg <= acc_addr[1:0];
    end
  end

  // memory port; request holds until the bus acknowledges
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem_req   <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_size  <= SZ_WORD;
      o_mem_addr  <= 32'h0;
      o_mem_wdata <= 32'h0;
    end else if (take_ok && (is_load || is_store)) begin
      o_mem_req   <= 1'b1;
      o_mem_we    <= is_store;
      o_mem_size  <= acc_size;
      o_mem_addr  <= acc_addr;
      o_mem_wdata <= wd_lanes;
    end else if (mem_end) begin
      o_mem_req   <= 1'b0;
      o_mem_we    <= 1'b0;
    end
  end

  // status outputs
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_instr_ready <= 1'b0;
      o_done        <= 1'b0;
      o_illegal     <= 1'b0;
      o_dbg_gpr     <= GPR_RST;
    end else begin
      o_instr_ready <= (state_next == ST_IDLE);
      o_done        <= (take_ok && (mov_gg || mov_sg || mov_gs || mov_pg)) ||
                       (mem_end && (pend_dst_reg != DST_PSW)) ||
                       (state_reg == ST_PSFIX);
      o_illegal     <= take && !legal;
      o_dbg_gpr     <= gpr_reg[i_dbg_sel];
    end
  end

  assign o_psw = psw_reg;

endmodule : lsm_core

`default_nettype wire

/* rtl/lsm_pkg.sv */
package lsm_pkg;

  // register file shape
  localparam int          GPR_NUM       = 16;
  localparam int          SPR_NUM       = 6;
  localparam logic [3:0]  IDX_BASE_GPR  = 4'hd;   // index_base_gpr
  localparam logic [3:0]  FRAME_GPR     = 4'he;   // frame_base_gpr
  localparam logic [3:0]  STACK_GPR     = 4'hf;   // stack_pointer_gpr
  localparam logic [31:0] STACK_STEP    = 32'h4;
  localparam logic [31:0] GPR_RST       = 32'h0;
  localparam logic [31:0] SPR_RST       = 32'h0;
  localparam logic [31:0] PSW_RST       = 32'h0;
  localparam int          FLAG_LSB      = 0;      // condition_flags sit in bits 3:0

  // access sizes
  localparam logic [1:0]  SZ_BYTE       = 2'h0;
  localparam logic [1:0]  SZ_HALF       = 2'h1;
  localparam logic [1:0]  SZ_WORD       = 2'h2;

  // opcodes, 8-bit forms
  localparam logic [7:0]  OP_LDW_IND    = 8'h04;
  localparam logic [7:0]  OP_LDH_IND    = 8'h05;
  localparam logic [7:0]  OP_LDB_IND    = 8'h06;
  localparam logic [7:0]  OP_LDW_IDX    = 8'h00;
  localparam logic [7:0]  OP_LDH_IDX    = 8'h01;
  localparam logic [7:0]  OP_LDB_IDX    = 8'h02;
  localparam logic [7:0]  OP_LDW_STK    = 8'h03;
  localparam logic [7:0]  OP_POP_GRP    = 8'h07;
  localparam logic [7:0]  OP_STW_IND    = 8'h14;
  localparam logic [7:0]  OP_STH_IND    = 8'h15;
  localparam logic [7:0]  OP_STB_IND    = 8'h16;
  localparam logic [7:0]  OP_STW_IDX    = 8'h10;
  localparam logic [7:0]  OP_STH_IDX    = 8'h11;
  localparam logic [7:0]  OP_STB_IDX    = 8'h12;
  localparam logic [7:0]  OP_STW_STK    = 8'h13;
  localparam logic [7:0]  OP_PUSH_GRP   = 8'h17;
  localparam logic [7:0]  OP_MOV_GG     = 8'h8b;
  localparam logic [7:0]  OP_MOV_SG     = 8'hb7;
  localparam logic [7:0]  OP_MOV_GS     = 8'hb3;

  // frame-relative forms, 4-bit opcode in bits 15:12
  localparam logic [3:0]  OPB_LDW_FRM   = 4'h2;
  localparam logic [3:0]  OPB_LDH_FRM   = 4'h4;
  localparam logic [3:0]  OPB_LDB_FRM   = 4'h6;
  localparam logic [3:0]  OPB_STW_FRM   = 4'h3;
  localparam logic [3:0]  OPB_STH_FRM   = 4'h5;
  localparam logic [3:0]  OPB_STB_FRM   = 4'h7;

  // sub-codes in bits 7:4 of the 07 / 17 groups
  localparam logic [3:0]  SUB_GPR       = 4'h0;
  localparam logic [3:0]  SUB_XFER      = 4'h1;
  localparam logic [3:0]  SUB_SPR       = 4'h8;
  localparam logic [3:0]  SUB_PSW       = 4'h9;

  // extra cycles a status word load costs after its data arrives
  localparam int          PSW_FIX_CYC   = 1;

  typedef enum logic [1:0] {
    DST_NONE,
    DST_GPR,
    DST_SPR,
    DST_PSW
  } lsm_dst_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEM,
    ST_PSFIX
  } lsm_state_t;

endpackage : lsm_pkg

/* rtl/lsm_lane_ext.sv */
`timescale 1ns/10ps
`default_nettype none

// big-endian lane steering: picks the addressed byte or half out of a read
// word and zero-extends it, and replicates store data over every lane
module lsm_lane_ext (
  input  wire logic [1:0]  i_size,
  input  wire logic [1:0]  i_lane,
  input  wire logic [31:0] i_rdata,
  input  wire logic [31:0] i_wdata,
  output logic      [31:0] o_rdata_ext,
  output logic      [31:0] o_wdata_lanes
);
  import lsm_pkg::*;

  wire logic [15:0] half_sel;
  wire logic [7:0]  byte_sel;

  // lane 0 is the most significant byte of the word
  assign half_sel      = i_lane[1] ? i_rdata[15:0] : i_rdata[31:16];
  assign byte_sel      = (i_lane == 2'h0) ? i_rdata[31:24] :
                         (i_lane == 2'h1) ? i_rdata[23:16] :
                         (i_lane == 2'h2) ? i_rdata[15:8]  : i_rdata[7:0];
  // narrow results are zero-extended, never sign-extended
  assign o_rdata_ext   = (i_size == SZ_WORD) ? i_rdata :
                         (i_size == SZ_HALF) ? {16'h0000, half_sel} :
                                               {24'h000000, byte_sel};
  // the bus picks the live lane from address and size
  assign o_wdata_lanes = (i_size == SZ_WORD) ? i_wdata :
                         (i_size == SZ_HALF) ? {2{i_wdata[15:0]}} :
                                               {4{i_wdata[7:0]}};

endmodule : lsm_lane_ext

`default_nettype wire

/* bench/lsm_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none

// behavioural bus controller: word memory of 64 entries, big-endian lanes
module lsm_mem_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [1:0]  i_size,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_delay,
  output logic             o_ack,
  output logic [31:0]      o_rdata
);
  logic [31:0] mem [64];
  logic [3:0]  wait_reg;
  logic [5:0]  idx;
  logic [31:0] lane_mask;

  // lane 0 is the top byte; only the addressed lanes are written
  assign idx       = i_addr[7:2];
  assign lane_mask = (i_size == 2'h2) ? 32'hffffffff :
                     (i_size == 2'h1) ? (i_addr[1] ? 32'h0000ffff : 32'hffff0000) :
                     (32'hff000000 >> {i_addr[1:0], 3'h0});

  // ack after i_delay idle cycles; read data never lingers past the ack
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ack    <= 1'b0;
      o_rdata  <= 32'h0;
      wait_reg <= 4'h0;
      for (int k = 0; k < 64; k++) begin
        mem[k] <= 32'h80000040 | (32'(k) << 8);
      end
    end else if (o_ack) begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
    end else if (i_req && wait_reg == i_delay) begin
      o_ack    <= 1'b1;
      wait_reg <= 4'h0;
      o_rdata  <= mem[idx];
      if (i_we) begin
        mem[idx] <= (mem[idx] & ~lane_mask) | (i_wdata & lane_mask);
      end
    end else begin
      wait_reg <= i_req ? wait_reg + 4'h1 : 4'h0;
      o_rdata  <= o_rdata + 32'h1; // keeps moving so stale data is never mistaken
    end
  end
endmodule : lsm_mem_model

`default_nettype wire

/* bench/lsm_core_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

// port-level checks on the instruction and memory sides of the core
module lsm_core_monitor (
  input wire logic        i_ref_clk,
  input wire logic        i_resetn,
  input wire logic [15:0] i_instr,
  input wire logic        i_instr_valid,
  input wire logic        o_instr_ready,
  input wire logic        o_done,
  input wire logic        o_illegal,
  input wire logic        o_mem_req,
  input wire logic        o_mem_we,
  input wire logic [1:0]  o_mem_size,
  input wire logic [31:0] o_mem_addr,
  input wire logic [31:0] o_mem_wdata,
  input wire logic        i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic [31:0] o_psw,
  input wire logic [3:0]  i_dbg_sel,
  input wire logic [31:0] o_dbg_gpr
);
  logic [15:0] cur_reg;
  logic        take;

  assign take = i_instr_valid && o_instr_ready;

  // remember the instruction in flight so its completion can be judged
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cur_reg <= 16'h0;
    end else if (take) begin
      cur_reg <= i_instr;
    end
  end

  default clocking mon_cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  req_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req
    && $stable(o_mem_addr) && $stable(o_mem_we) && $stable(o_mem_size) && $stable(o_mem_wdata))
    else $error("memory request changed before ack");
  ack_done_a: assert property (o_mem_req && i_mem_ack |=> !o_mem_req
    && (o_done != (cur_reg[15:4] == 12'h079)))
    else $error("completion not one cycle after ack");
  pop_flags_a: assert property (o_mem_req && i_mem_ack && cur_reg[15:4] == 12'h079
    |=> ##1 o_done && o_psw[3:0] == $past(i_mem_rdata[3:0], 2))
    else $error("status pop flags or timing wrong");
  size_kind_a: assert property (take && i_instr[15:8] inside
    {8'h04, 8'h05, 8'h06, 8'h14, 8'h15, 8'h16} |=> o_mem_req && !o_instr_ready
    && o_mem_size == 2'h2 - $past(i_instr[9:8]) && o_mem_we == $past(i_instr[12]))
    else $error("indirect access size or direction wrong");
  // a special-register form naming a missing register is refused, so it is left out here
  stack_word_a: assert property (take
    && (i_instr[15:8] & 8'hef) == 8'h07 && i_instr[7:4] inside {4'h0, 4'h8, 4'h9}
    && !(i_instr[7:4] == 4'h8 && i_instr[3:0] > 4'h5)
    |=> o_mem_req && o_mem_size == 2'h2 && o_mem_we == $past(i_instr[12]))
    else $error("push or pop access wrong");
  mov_gpr_a: assert property (take && i_instr[15:8] == 8'h8b
    |=> o_done && !o_mem_req && $stable(o_psw))
    else $error("register copy not single cycle");
  mov_spr_a: assert property (take && i_instr[15:8] inside {8'hb7, 8'hb3}
    && i_instr[7:4] < 4'h6 |=> o_done && !o_mem_req)
    else $error("special register copy not single cycle");
  psw_load_a: assert property (take && i_instr[15:4] == 12'h071
    |=> !o_done && !o_instr_ready ##1 o_done)
    else $error("status load timing wrong");
  busy_req_a: assert property (o_mem_req |-> !o_instr_ready && !o_done)
    else $error("ready or done while memory busy");
  refuse_a: assert property (o_illegal |-> o_instr_ready && !o_done && !o_mem_req
    && $stable(o_psw))
    else $error("refused word had an effect");
endmodule : lsm_core_monitor

bind lsm_core lsm_core_monitor lsm_core_monitor_inst (
  .i_ref_clk, .i_resetn, .i_instr, .i_instr_valid, .o_instr_ready, .o_done, .o_illegal,
  .o_mem_req, .o_mem_we, .o_mem_size, .o_mem_addr, .o_mem_wdata, .i_mem_ack,
  .i_mem_rdata, .o_psw, .i_dbg_sel, .o_dbg_gpr
);

`default_nettype wire

/* bench/test_lsm_core.sv */
`timescale 1ns/10ps
`default_nettype none

module test_lsm_core;
  logic        i_ref_clk;
  logic        i_resetn;
  logic [15:0] i_instr;
  logic        i_instr_valid;
  logic        o_instr_ready;
  logic        o_done;
  logic        o_illegal;
  logic        o_mem_req;
  logic        o_mem_we;
  logic [1:0]  o_mem_size;
  logic [31:0] o_mem_addr;
  logic [31:0] o_mem_wdata;
  logic        i_mem_ack;
  logic [31:0] i_mem_rdata;
  logic [31:0] o_psw;
  logic [3:0]  i_dbg_sel;
  logic [31:0] o_dbg_gpr;
  logic [3:0]  dly;
  int          num_errors;
  int          tests_run;

  lsm_core lsm_core_inst (
    .i_ref_clk, .i_resetn, .i_instr, .i_instr_valid, .o_instr_ready, .o_done, .o_illegal,
    .o_mem_req, .o_mem_we, .o_mem_size, .o_mem_addr, .o_mem_wdata, .i_mem_ack,
    .i_mem_rdata, .o_psw, .i_dbg_sel, .o_dbg_gpr
  );

  lsm_mem_model lsm_mem_model_inst (
    .i_ref_clk, .i_resetn, .i_req(o_mem_req), .i_we(o_mem_we), .i_size(o_mem_size),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_delay(dly), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata)
  );

  // 250 MHz core clock
  always #2 i_ref_clk = ~i_ref_clk;

  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask : chk

  // offer one word; n is cycles from take to done, negative means refused
  task automatic op(input logic [15:0] ins, input int n, input logic w,
                    input logic [1:0] sz, input logic [31:0] a, input logic [31:0] wd);
    int k;
    @(negedge i_ref_clk);
    for (k = 0; k < 50 && o_instr_ready !== 1'b1; k++) @(negedge i_ref_clk);
    if (k == 50) begin
      num_errors++;
      end_sim();
    end
    i_instr       = ins;
    i_instr_valid = 1'b1;
    @(negedge i_ref_clk);
    i_instr_valid = 1'b0;
    if (n < 0) begin
      chk("illegal", 32'h1, 32'(o_illegal));
      chk("ready", 32'h1, 32'(o_instr_ready));
      return;
    end
    if (n > 1) begin
      chk("req", 32'h1, 32'(o_mem_req));
      chk("we", 32'(w), 32'(o_mem_we));
      chk("size", 32'(sz), 32'(o_mem_size));
      chk("addr", a, o_mem_addr);
      if (w) chk("wdata", wd, o_mem_wdata);
    end
    for (k = 0; k < 40 && o_done !== 1'b1; k++) @(negedge i_ref_clk);
    if (k == 40) begin
      num_errors++;
      end_sim();
    end
    chk("cycles", 32'(n), 32'(k));
  endtask : op

  // view one general register through the debug port
  task automatic rchk(input logic [3:0] r, input logic [31:0] e);
    @(negedge i_ref_clk);
    i_dbg_sel = r;
    @(negedge i_ref_clk);
    chk("gpr", e, o_dbg_gpr);
  endtask : rchk

  task automatic t_loads;
    dly = 4'h0;
    op(16'h0401, 2, 0, 2'h2, 32'h0, 32'h0);
    op(16'h0502, 2, 0, 2'h1, 32'h0, 32'h0);
    op(16'h0603, 2, 0, 2'h0, 32'h0, 32'h0);
    dly = 4'h3;
    op(16'h041d, 5, 0, 2'h2, 32'h80000040, 32'h0);
    op(16'h0034, 5, 0, 2'h2, 32'h800010c0, 32'h0);
    op(16'h0135, 5, 0, 2'h1, 32'h800010c0, 32'h0);
    op(16'h0236, 5, 0, 2'h0, 32'h800010c0, 32'h0);
    dly = 4'h0;
    op(16'h2817, 2, 0, 2'h2, 32'hfffffe04, 32'h0);
    op(16'h4ff8, 2, 0, 2'h1, 32'hfffffffe, 32'h0);
    op(16'h6169, 2, 0, 2'h0, 32'h00000016, 32'h0);
    op(16'h035a, 2, 0, 2'h2, 32'h00000014, 32'h0);
    rchk(4'h1, 32'h80000040);
    rchk(4'h2, 32'h00008000);
    rchk(4'h3, 32'h00000080);
    rchk(4'h4, 32'h80003040);
    rchk(4'h5, 32'h00008000);
    rchk(4'h6, 32'h00000080);
    rchk(4'h7, 32'h80000140);
    rchk(4'h8, 32'h00003f40);
    rchk(4'h9, 32'h00000005);
    rchk(4'ha, 32'h80000540);
  endtask : t_loads

  task automatic t_stack;
    op(16'h041f, 2, 0, 2'h2, 32'h80000040, 32'h0);
    dly = 4'h2;
    op(16'h1701, 4, 1, 2'h2, 32'h8000103c, 32'h80000040);
    dly = 4'h0;
    op(16'h070b, 2, 0, 2'h2, 32'h8000103c, 32'h0);
    rchk(4'hb, 32'h80000040);
    op(16'hb329, 0, 0, 2'h0, 32'h0, 32'h0);
    op(16'h1782, 2, 1, 2'h2, 32'h8000103c, 32'h5);
    op(16'h0783, 2, 0, 2'h2, 32'h8000103c, 32'h0);
    op(16'hb73c, 0, 0, 2'h0, 32'h0, 32'h0);
    rchk(4'hc, 32'h5);
    op(16'h0719, 1, 0, 2'h0, 32'h0, 32'h0);
    chk("psw", 32'h5, o_psw);
    op(16'h1716, 0, 0, 2'h0, 32'h0, 32'h0);
    rchk(4'h6, 32'h5);
    op(16'h1790, 2, 1, 2'h2, 32'h8000103c, 32'h5);
    op(16'h0710, 1, 0, 2'h0, 32'h0, 32'h0);
    chk("psw", 32'h0, o_psw);
    op(16'h0790, 3, 0, 2'h2, 32'h8000103c, 32'h0);
    chk("psw", 32'h5, o_psw);
    rchk(4'hf, 32'h80001040);
    op(16'h8ba6, 0, 0, 2'h0, 32'h0, 32'h0);
    chk("psw", 32'h5, o_psw);
    rchk(4'h6, 32'h80000540);
  endtask : t_stack

  task automatic t_stores;
    dly = 4'h1;
    op(16'h1421, 3, 1, 2'h2, 32'h00008000, 32'h80000040);
    op(16'h1538, 3, 1, 2'h1, 32'h00000080, 32'h3f403f40);
    op(16'h1639, 3, 1, 2'h0, 32'h00000080, 32'h05050505);
    op(16'h1002, 3, 1, 2'h2, 32'h80001040, 32'h00008000);
    op(16'h1139, 3, 1, 2'h1, 32'h800010c0, 32'h00050005);
    op(16'h1293, 3, 1, 2'h0, 32'h80001045, 32'h80808080);
    op(16'h3811, 3, 1, 2'h2, 32'hfffffe04, 32'h80000040);
    op(16'h5ff9, 3, 1, 2'h1, 32'hfffffffe, 32'h00050005);
    op(16'h7168, 3, 1, 2'h0, 32'h00000016, 32'h40404040);
    op(16'h135a, 3, 1, 2'h2, 32'h80001054, 32'h80000540);
  endtask : t_stores

  // undefined word and out-of-range special registers are refused, stack untouched
  task automatic t_bad;
    op(16'hff00, -1, 0, 2'h0, 32'h0, 32'h0);
    op(16'hb761, -1, 0, 2'h0, 32'h0, 32'h0);
    rchk(4'h1, 32'h80000040);
    op(16'h0787, -1, 0, 2'h0, 32'h0, 32'h0);
    op(16'h1787, -1, 0, 2'h0, 32'h0, 32'h0);
    rchk(4'hf, 32'h80001040);
  endtask : t_bad

  // reset, then every scenario in turn
  initial begin
    i_ref_clk     = 1'b0;
    i_resetn      = 1'b0;
    i_instr       = 16'h0;
    i_instr_valid = 1'b0;
    i_dbg_sel     = 4'h0;
    dly           = 4'h0;
    num_errors    = 0;
    tests_run     = 0;
    repeat (16) @(negedge i_ref_clk);
    chk("rst size", 32'h2, 32'(o_mem_size));
    chk("rst ready", 32'h0, 32'(o_instr_ready));
    i_resetn = 1'b1;
    t_loads();
    t_stack();
    t_stores();
    t_bad();
    end_sim();
  end
endmodule : test_lsm_core

`default_nettype wire
